// ==== verilog/chl_loader.v ====
// Console hardware loader: octal assembly of words from the operator
// terminal or the tape reader while the processor is halted.
// Assumes character sources, memory and processor all run on clk;
// the selector switch is a panel pin and is synchronised in the lamp selector.
`timescale 1ns/1ns
`default_nettype none
`include "chl_map.vh"

module chl_loader #(
    parameter NREG       = 11,
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW    = 3
) (
    input  wire               clk,
    input  wire               sys_rst,
    input  wire               halted,
    input  wire [7:0]         term_data,
    input  wire               term_valid,
    output wire               term_ready,
    input  wire [7:0]         tape_data,
    input  wire               tape_valid,
    output wire               tape_ready,
    output reg                mem_req,
    output reg                mem_we,
    output reg  [15:0]        mem_addr,
    output reg  [15:0]        mem_wdata,
    input  wire [15:0]        mem_rdata,
    input  wire               mem_ack,
    output reg                pc_load,
    output reg  [15:0]        pc_value,
    output reg                start_run,
    output reg                tape_lamp,
    output reg                ir_force,
    output reg  [15:0]        io_transfer_instruction,
    output reg  [15:0]        holding,
    output reg                illegal_char,
    input  wire [3:0]         sel_switch,
    input  wire [NREG*16-1:0] reg_bank,
    output wire [15:0]        lamp
);
    // One-hot states of the command sequencer
    localparam ST_IDLE  = 3'b001;
    localparam ST_READ  = 3'b010;
    localparam ST_WRITE = 3'b100;

    reg  [2:0]  state_reg;
    reg  [2:0]  state_next;
    reg         halted_d_reg;
    reg         digit_seen_reg;
    reg         digit_seen_next;
    reg         tape_mode_next;
    reg  [15:0] hold_next;
    reg  [15:0] mar_next;
    reg         req_next;
    reg         we_next;
    reg  [15:0] wdata_next;
    reg         pc_load_next;
    reg  [15:0] pc_value_next;
    reg         illegal_next;

    wire        stop_entry;
    wire        active;
    wire [7:0]  src_data;
    wire        src_valid;
    wire        fifo_in_ready;
    wire [7:0]  ch_data;
    wire        ch_valid;
    wire        ch_pop;
    wire [2:0]  ch_class;

    // Classify a 7-bit character; '!' counts only while reading tape
    function [2:0] chl_classify;
        input [6:0] ch;
        input       from_tape;
        begin
            if (ch >= `CHL_CH_ZERO && ch <= `CHL_CH_SEVEN) begin
                chl_classify = `CHL_CL_DIGIT;
            end else if (ch == `CHL_CH_SLASH) begin
                chl_classify = `CHL_CL_SLASH;
            end else if (ch == `CHL_CH_COLON) begin
                chl_classify = `CHL_CL_COLON;
            end else if (ch == `CHL_CH_CR) begin
                chl_classify = `CHL_CL_CR;
            end else if (ch == `CHL_CH_DOLLAR) begin
                chl_classify = `CHL_CL_DOLLAR;
            end else if (ch == `CHL_CH_AT) begin
                chl_classify = `CHL_CL_AT;
            end else if (ch == `CHL_CH_BANG && from_tape) begin
                chl_classify = `CHL_CL_BANG;
            end else begin
                chl_classify = `CHL_CL_ILLEGAL;
            end
        end
    endfunction

    // forced word
    // Decoded in one place so the word matches the tape lamp whenever halted
    function [15:0] chl_xfer_word;
        input from_tape;
        begin
            if (from_tape) begin
                chl_xfer_word = `CHL_XFER_TAPE;
            end else begin
                chl_xfer_word = `CHL_XFER_TERMINAL;
            end
        end
    endfunction

    // halted only
    // Stop-mode edge; the loader stays idle in the entry cycle so that
    // the source reset below wins over any character taken then.
    assign stop_entry = halted & ~halted_d_reg;
    assign active     = halted & halted_d_reg;

    // source select
    // Only the selected source sees ready; the other one is held off.
    assign src_data   = tape_lamp ? tape_data : term_data;
    assign src_valid  = active & (tape_lamp ? tape_valid : term_valid);
    assign term_ready = active & ~tape_lamp & fifo_in_ready;
    assign tape_ready = active & tape_lamp & fifo_in_ready;

    // Characters queue here; the sequencer stalls them during memory cycles
    // Eight entries hold a full word of digits typed during a slow memory cycle
    chl_fifo #(
        .WIDTH    (8),
        .DEPTH    (FIFO_DEPTH),
        .AW       (FIFO_AW)
    ) chl_fifo_inst (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .in_data  (src_data),
        .in_valid (src_valid),
        .in_ready (fifo_in_ready),
        .out_data (ch_data),
        .out_valid(ch_valid),
        .out_ready(ch_pop)
    );

    // The sequencer takes one character per cycle only when idle
    // Popping outside idle would lose the character behind a memory cycle
    assign ch_pop   = ch_valid & active & (state_reg == ST_IDLE);
    assign ch_class = chl_classify(ch_data[6:0], tape_lamp);

    // Next-state and datapath decisions
    // Defaults hold every register except the pulses, which default to zero, so no path leaves a latch behind
    always @* begin
        state_next      = state_reg;
        digit_seen_next = digit_seen_reg;
        tape_mode_next  = tape_lamp;
        hold_next       = holding;
        mar_next        = mem_addr;
        req_next        = mem_req;
        we_next         = mem_we;
        wdata_next      = mem_wdata;
        pc_load_next    = 1'b0;
        pc_value_next   = pc_value;
        illegal_next    = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (ch_pop) begin
                    case (ch_class)
                        `CHL_CL_DIGIT: begin
                            hold_next = {holding[12:0],
                                         ch_data[`CHL_DIGIT_MSB:`CHL_DIGIT_LSB]};
                            digit_seen_next = 1'b1;
                        end
                        `CHL_CL_SLASH: begin
                            mar_next   = holding;
                            req_next   = 1'b1;
                            we_next    = 1'b0;
                            state_next = ST_READ;
                        end
                        `CHL_CL_COLON: begin
                            pc_value_next = holding;
                            pc_load_next  = 1'b1;
                        end
                        `CHL_CL_CR: begin
                            if (digit_seen_reg) begin
                                req_next        = 1'b1;
                                we_next         = 1'b1;
                                wdata_next      = holding;
                                digit_seen_next = 1'b0;
                                state_next      = ST_WRITE;
                            end
                        end
                        `CHL_CL_DOLLAR: begin
                            tape_mode_next = 1'b1;
                        end
                        `CHL_CL_AT: begin
                            tape_mode_next = 1'b0;
                        end
                        `CHL_CL_BANG: begin
                            tape_mode_next = 1'b0;
                        end
                        default: begin
                            illegal_next = 1'b1;
                        end
                    endcase
                end
            end
            ST_READ: begin
                if (mem_ack) begin
                    hold_next  = mem_rdata;
                    req_next   = 1'b0;
                    state_next = ST_IDLE;
                end
            end
            ST_WRITE: begin
                if (mem_ack) begin
                    mar_next   = mem_addr + 16'h0001;
                    req_next   = 1'b0;
                    we_next    = 1'b0;
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
                req_next   = 1'b0;
                we_next    = 1'b0;
            end
        endcase
        if (stop_entry) begin
            tape_mode_next  = 1'b0;
            digit_seen_next = 1'b0;
        end
    end

    // Sequencer state and holding word
    always @(posedge clk) begin
        if (sys_rst) begin
            state_reg      <= ST_IDLE;
            halted_d_reg   <= 1'b0;
            digit_seen_reg <= 1'b0;
            holding        <= `CHL_WORD_RST;
        end else begin
            state_reg      <= state_next;
            halted_d_reg   <= halted;
            digit_seen_reg <= digit_seen_next;
            holding        <= hold_next;
        end
    end

    // Memory request registers
    // All four load on the same edge from one decision, so a request is never torn
    always @(posedge clk) begin
        if (sys_rst) begin
            mem_addr  <= `CHL_WORD_RST;
            mem_req   <= 1'b0;
            mem_we    <= 1'b0;
            mem_wdata <= `CHL_WORD_RST;
        end else begin
            mem_addr  <= mar_next;
            mem_req   <= req_next;
            mem_we    <= we_next;
            mem_wdata <= wdata_next;
        end
    end

    // Run control and error pulses
    // Each pulse lasts one cycle; the processor must latch start_run itself
    always @(posedge clk) begin
        if (sys_rst) begin
            pc_load      <= 1'b0;
            pc_value     <= `CHL_WORD_RST;
            start_run    <= 1'b0;
            illegal_char <= 1'b0;
        end else begin
            pc_load      <= pc_load_next;
            pc_value     <= pc_value_next;
            start_run    <= pc_load_next;
            illegal_char <= illegal_next;
        end
    end

    // clear drops tape
    // System clear and stop entry both reset it; each returns to the terminal.
    always @(posedge clk) begin
        if (sys_rst) begin
            tape_lamp <= 1'b0;
        end else begin
            tape_lamp <= tape_mode_next;
        end
    end

    // forced instruction
    // The word follows the source in the same cycle as tape_lamp; it is zero when running.
    always @(posedge clk) begin
        if (sys_rst) begin
            ir_force                <= 1'b0;
            io_transfer_instruction <= `CHL_WORD_RST;
        end else if (halted) begin
            ir_force                <= 1'b1;
            io_transfer_instruction <= chl_xfer_word(tape_mode_next);
        end else begin
            ir_force                <= 1'b0;
            io_transfer_instruction <= `CHL_WORD_RST;
        end
    end

    // lamp display
    // The selector synchronises the panel switch on its own
    chl_lamp_sel #(
        .NREG      (NREG)
    ) chl_lamp_sel_inst (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .sel_switch(sel_switch),
        .reg_bank  (reg_bank),
        .lamp      (lamp)
    );
endmodule

`default_nettype wire

// ==== inc/chl_map.vh ====
// Constants of the console hardware loader: character codes, forced
// instruction words, reset values and the digit field of the character code.
// Assumes 7-bit character codes; the eighth bit is ignored by the loader.
`ifndef CHL_MAP_VH
`define CHL_MAP_VH

// Character codes seen by the loader
`define CHL_CH_ZERO      7'h30
`define CHL_CH_SEVEN     7'h37
`define CHL_CH_SLASH     7'h2f
`define CHL_CH_COLON     7'h3a
`define CHL_CH_CR        7'h0d
`define CHL_CH_DOLLAR    7'h24
`define CHL_CH_AT        7'h40
`define CHL_CH_BANG      7'h21

// Character classes returned by the decode function
`define CHL_CL_ILLEGAL   3'h0
`define CHL_CL_DIGIT     3'h1
`define CHL_CL_SLASH     3'h2
`define CHL_CL_COLON     3'h3
`define CHL_CL_CR        3'h4
`define CHL_CL_DOLLAR    3'h5
`define CHL_CL_AT        3'h6
`define CHL_CL_BANG      3'h7

// Forced input/output transfer instruction, octal 161402 and 161422
`define CHL_XFER_TERMINAL 16'he302
`define CHL_XFER_TAPE     16'he312

// Reset values
`define CHL_WORD_RST     16'h0000
`define CHL_SEL_RST      4'h0

// Digit field of the character code
`define CHL_DIGIT_LSB    0
`define CHL_DIGIT_MSB    2

`endif

// ==== verilog/chl_fifo.v ====
// Character FIFO between the selected source and the interpreter.
// Assumes both sides on clk; synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none

module chl_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk,
    input  wire             sys_rst,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg  [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg  [AW-1:0]    wr_ptr_reg;
    reg  [AW-1:0]    rd_ptr_reg;
    reg  [AW:0]      count_reg;
    wire             push;
    wire             pop;

    // Full and empty come straight from the occupancy count
    assign in_ready  = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data  = mem_reg[rd_ptr_reg];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Storage has no reset; only the pointers and the count need a defined value
    always @(posedge clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers wrap on DEPTH, which must be a power of two
    always @(posedge clk) begin
        if (sys_rst) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push & ~pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop & ~push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// ==== verilog/chl_lamp_sel.v ====
// Indicator lamp selector: picks one processor register by switch position.
// Assumes the switch is asynchronous and the registers are on clk.
`timescale 1ns/1ns
`default_nettype none
`include "chl_map.vh"

module chl_lamp_sel #(
    parameter NREG = 11
) (
    input  wire               clk,
    input  wire               sys_rst,
    input  wire [3:0]         sel_switch,
    input  wire [NREG*16-1:0] reg_bank,
    output reg  [15:0]        lamp
);
    reg  [3:0] sel_meta_reg;
    reg  [3:0] sel_sync_reg;

    // Two-stage synchroniser for the panel switch
    always @(posedge clk) begin
        if (sys_rst) begin
            sel_meta_reg <= `CHL_SEL_RST;
            sel_sync_reg <= `CHL_SEL_RST;
        end else begin
            sel_meta_reg <= sel_switch;
            sel_sync_reg <= sel_meta_reg;
        end
    end

    // Unused switch positions show dark lamps
    always @(posedge clk) begin
        if (sys_rst) begin
            lamp <= `CHL_WORD_RST;
        end else if (sel_sync_reg < NREG) begin
            lamp <= reg_bank[sel_sync_reg*16 +: 16];
        end else begin
            lamp <= `CHL_WORD_RST;
        end
    end
endmodule

`default_nettype wire

// ==== bench/chl_checker.sv ====
// Timing checks on the console loader's ports.
// Assumes a bind onto chl_loader; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
`include "chl_map.vh"

module chl_checker #(
    parameter NREG = 11
) (
    input wire logic               clk,
    input wire logic               sys_rst,
    input wire logic               halted,
    input wire logic               term_ready,
    input wire logic               tape_ready,
    input wire logic               mem_req,
    input wire logic               mem_we,
    input wire logic [15:0]        mem_addr,
    input wire logic [15:0]        mem_wdata,
    input wire logic [15:0]        mem_rdata,
    input wire logic               mem_ack,
    input wire logic               pc_load,
    input wire logic [15:0]        pc_value,
    input wire logic               start_run,
    input wire logic               tape_lamp,
    input wire logic               ir_force,
    input wire logic [15:0]        io_transfer_instruction,
    input wire logic [15:0]        holding,
    input wire logic               illegal_char,
    input wire logic [3:0]         sel_switch,
    input wire logic [NREG*16-1:0] reg_bank,
    input wire logic [15:0]        lamp
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_lamp_follows: assert property (($stable(sel_switch) && $stable(reg_bank))[*4]
        |-> lamp == (sel_switch < NREG ? reg_bank[sel_switch*16 +: 16] : 16'h0000))
        else $error("lamp does not show the selected register");
    a_ready_gated: assert property ((term_ready |-> halted && !tape_lamp)
        and (tape_ready |-> halted && tape_lamp))
        else $error("character source ready out of turn");
    a_read_address: assert property ($rose(mem_req) && !mem_we |-> mem_addr == holding)
        else $error("read address differs from holding word");
    a_read_fills: assert property (mem_req && !mem_we && mem_ack |=>
        holding == $past(mem_rdata) && !mem_req)
        else $error("read data not placed in holding word");
    a_start_pairs: assert property (pc_load |-> start_run && pc_value == holding)
        else $error("start without matching counter load");
    a_write_data: assert property ($rose(mem_req) && mem_we |-> mem_wdata == holding)
        else $error("write data differs from holding word");
    a_write_bumps: assert property (mem_req && mem_we && mem_ack |=>
        mem_addr == $past(mem_addr) + 16'h0001)
        else $error("address not incremented after write");
    a_req_held: assert property (mem_req && !mem_ack |=>
        mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata))
        else $error("memory request changed before acknowledge");
    a_entry_terminal: assert property ($rose(halted) |=> !tape_lamp)
        else $error("stop entry left tape source selected");
    a_xfer_word: assert property (ir_force && tape_lamp == $past(tape_lamp)
        && tape_lamp == $past(tape_lamp, 2)
        |-> io_transfer_instruction == (tape_lamp ? `CHL_XFER_TAPE : `CHL_XFER_TERMINAL))
        else $error("forced instruction word wrong for source");
    a_clear_tape: assert property (@(posedge clk) disable iff (1'b0)
        sys_rst |=> !tape_lamp)
        else $error("system clear left tape source lit");
    a_illegal_quiet: assert property (illegal_char |-> $stable(holding)
        && $stable(mem_addr) && !pc_load && !$rose(mem_req))
        else $error("illegal character changed loader state");

    // Main scenarios reached
    c_start: cover property (pc_load);
    c_write: cover property (mem_ack && mem_we);
    c_tape: cover property ($rose(tape_lamp));
endmodule

bind chl_loader chl_checker #(.NREG(NREG)) chl_checker_inst (.clk, .sys_rst, .halted,
    .term_ready, .tape_ready, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack,
    .pc_load, .pc_value, .start_run, .tape_lamp, .ir_force, .io_transfer_instruction,
    .holding, .illegal_char, .sel_switch, .reg_bank, .lamp);
`default_nettype wire

// ==== bench/chl_char_src.sv ====
// Operator terminal or tape reader: offers characters on valid/ready.
// Assumes ready is combinational and sampled at the falling edge before the transfer edge.
`timescale 1ns/1ns
`default_nettype none

module chl_char_src (
    input  wire logic       clk,
    output var  logic [7:0] data,
    output var  logic       valid,
    input  wire logic       ready
);
    initial begin
        data = 8'h00;
        valid = 1'b0;
    end

    // Sends a string back to back; released data shows the inverse so no stale match
    task automatic send(input string s, output bit ok);
        int i;
        int n;
        begin
            ok = 1'b1;
            for (i = 0; i < s.len(); i++) begin
                data = s[i];
                valid = 1'b1;
                for (n = 0; n < 500; n++) begin
                    @(negedge clk);
                    if (ready === 1'b1) break;
                end
                if (n == 500) ok = 1'b0;
                @(posedge clk);
                #1;
            end
            valid = 1'b0;
            data = ~data;
        end
    endtask
endmodule
`default_nettype wire

// ==== bench/console_hardware_loader_test.sv ====
// Self-checking bench for the console loader with a small memory model.
// Assumes chl_loader, chl_fifo, chl_lamp_sel and chl_char_src are compiled.
`timescale 1ns/1ns
`default_nettype none

module console_hardware_loader_test;
    logic clk = 1'b0, sys_rst = 1'b1, halted = 1'b1, mem_ack = 1'b0, mem_stall = 1'b0;
    logic [15:0] mem_rdata = 16'h0000, mem [0:255];
    logic [3:0] sel_switch = 4'h0;
    logic [175:0] reg_bank = '0;
    wire logic [7:0] term_data, tape_data;
    wire logic term_valid, tape_valid, term_ready, tape_ready, mem_req, mem_we, pc_load;
    wire logic start_run, tape_lamp, ir_force, illegal_char;
    wire logic [15:0] mem_addr, mem_wdata, pc_value, io_transfer_instruction, holding, lamp;
    int mismatches = 0, total_checks = 0, n_ill = 0, n_start = 0, wait_cnt = 0;

    always #5 clk = ~clk;

    chl_loader chl_loader_inst (.clk, .sys_rst, .halted, .term_data, .term_valid, .term_ready,
        .tape_data, .tape_valid, .tape_ready, .mem_req, .mem_we, .mem_addr, .mem_wdata,
        .mem_rdata, .mem_ack, .pc_load, .pc_value, .start_run, .tape_lamp, .ir_force,
        .io_transfer_instruction, .holding, .illegal_char, .sel_switch, .reg_bank, .lamp);
    chl_char_src term_src (.clk, .data(term_data), .valid(term_valid), .ready(term_ready));
    chl_char_src tape_src (.clk, .data(tape_data), .valid(tape_valid), .ready(tape_ready));

    // Memory answers after two cycles unless stalled; data is only valid with ack
    always @(posedge clk) begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_req && !mem_ack && !mem_stall) begin
            wait_cnt <= wait_cnt + 1;
            if (wait_cnt == 1) begin
                wait_cnt <= 0;
                mem_ack <= 1'b1;
                mem_rdata <= mem[mem_addr[7:0]];
                if (mem_we) mem[mem_addr[7:0]] <= mem_wdata;
            end
        end
        if (illegal_char === 1'b1) n_ill <= n_ill + 1;
        if (start_run === 1'b1) n_start <= n_start + 1;
    end

    task close_out;
        if (mismatches == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task put(input bit tape, input string s);
        bit ok;
        if (tape) tape_src.send(s, ok);
        else term_src.send(s, ok);
        if (!ok) begin
            mismatches++;
            close_out;
        end
    endtask

    // Bounded wait for the memory side to go quiet
    task idle;
        int q;
        int n;
        q = 0;
        for (n = 0; n < 300 && q < 12; n++) begin
            @(posedge clk);
            q = (mem_req === 1'b0) ? q + 1 : 0;
        end
        #1;
        if (q < 12) begin
            mismatches++;
            close_out;
        end
    endtask

    task t_lamp;
        sel_switch = 4'h3;
        repeat (5) @(posedge clk);
        #1 check(lamp, 16'ha003);
        sel_switch = 4'hc;
        repeat (5) @(posedge clk);
        #1 check(lamp, 16'h0000);
    endtask

    task t_deposit;
        mem[8'h40] = 16'h1234;
        put(0, "100/");
        idle;
        check(holding, 16'h1234);
        put(0, "000004\015040003\015\015");
        idle;
        check(mem[8'h40], 16'h0004);
        check(mem[8'h41], 16'h4003);
        check(mem_addr, 16'h0042);
        check(mem[8'h42], 16'h0000);
        put(0, "1234567");
        idle;
        check(holding, 16'h3977);
    endtask

    task t_illegal;
        int n0;
        n0 = n_ill;
        put(0, "x!@");
        idle;
        check(holding, 16'h3977);
        check(mem_addr, 16'h0042);
        check(16'(n_ill - n0), 16'h0002);
    endtask

    task t_fifo;
        mem_stall = 1'b1;
        put(0, "/12345670");
        @(negedge clk);
        check({15'h0000, term_ready}, 16'h0000);
        @(posedge clk);
        #1 mem_stall = 1'b0;
        idle;
        check(holding, 16'hcbb8);
    endtask

    task t_start;
        int n0;
        n0 = n_start;
        put(0, "000100:");
        idle;
        check(pc_value, 16'h0040);
        check(16'(n_start - n0), 16'h0001);
        halted = 1'b0;
        repeat (3) @(posedge clk);
        #1 check({15'h0000, term_ready}, 16'h0000);
        check(io_transfer_instruction, 16'h0000);
        check({15'h0000, ir_force}, 16'h0000);
        halted = 1'b1;
        repeat (3) @(posedge clk);
        #1 check(io_transfer_instruction, 16'he302);
        check({15'h0000, ir_force}, 16'h0001);
    endtask

    task t_tape;
        put(0, "$");
        idle;
        check({15'h0000, tape_lamp}, 16'h0001);
        check(io_transfer_instruction, 16'he312);
        put(1, "000077\015@");
        idle;
        check(mem[8'h77], 16'h003f);
        check({15'h0000, tape_lamp}, 16'h0000);
        put(0, "$");
        idle;
        put(1, "!");
        idle;
        check({15'h0000, tape_lamp}, 16'h0000);
        put(0, "$");
        idle;
        halted = 1'b0;
        @(posedge clk);
        #1 halted = 1'b1;
        repeat (3) @(posedge clk);
        #1 check({15'h0000, tape_lamp}, 16'h0000);
        put(0, "$");
        idle;
        check({15'h0000, tape_lamp}, 16'h0001);
        sys_rst = 1'b1;
        @(posedge clk);
        #1 sys_rst = 1'b0;
        check({15'h0000, tape_lamp}, 16'h0000);
    endtask

    // Main sequence: reset, then scenarios in order
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 16'h0000;
        for (int i = 0; i < 11; i++) reg_bank[i*16 +: 16] = 16'ha000 + 16'(i);
        repeat (20) @(posedge clk);
        #1 sys_rst = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        t_lamp;
        t_deposit;
        t_illegal;
        t_fifo;
        t_start;
        t_tape;
        close_out;
    end
endmodule
`default_nettype wire
